// ===== core/htc_pkg.sv
/*
  Package for the fast TIA and DAC offset configuration block: register byte
  offsets, field positions, reset values and decode codes.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package htc_pkg;

  // ***************************************************************
  // Register byte offsets
  // ***************************************************************
  localparam logic [15:0] OFS_CAL_LOCK      = 16'h2000;
  localparam logic [15:0] OFS_FRONT_END     = 16'h2004;
  localparam logic [15:0] OFS_FAST_DAC      = 16'h2008;
  localparam logic [15:0] OFS_FAST_GAIN_RES = 16'h20F0;
  localparam logic [15:0] OFS_ELECTRODE_RES = 16'h20F8;
  localparam logic [15:0] OFS_TIA_CFG       = 16'h20FC;
  localparam logic [15:0] OFS_DAC_OFFSET_HS = 16'h22BC;
  localparam logic [15:0] OFS_STATUS        = 16'h2100;

  // ***************************************************************
  // Field positions and widths
  // ***************************************************************
  localparam int LOCK_BIT       = 0;
  localparam int TIA_EN_BIT     = 11;
  localparam int ATTEN_BIT      = 12;
  localparam int DAC_MODE_BIT   = 0;
  localparam int OFFSET_W       = 12;
  localparam int GAIN_RES_W     = 13;
  localparam int GAIN_FIELD_W   = 4;
  localparam int ELEC_W         = 8;
  localparam int INSEL_LSB      = 0;
  localparam int CM_BIT         = 3;
  localparam int ADC_CH_LSB     = 4;
  localparam int ADC_CH_W       = 5;
  localparam int TIA_CFG_W      = 9;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [12:0] RST_FAST_GAIN_RES = 13'h000F;
  localparam logic [7:0]  RST_ELECTRODE_RES = 8'hFF;
  localparam logic [11:0] RST_DAC_OFFSET    = 12'h000;

  // ***************************************************************
  // Codes
  // ***************************************************************
  localparam logic [7:0] ELEC_SHORT_CODE = 8'h97;
  localparam logic [3:0] GAIN_EXT_CODE   = 4'hF;
  localparam logic [4:0] ADC_CH_TIA      = 5'h01;
  localparam logic [3:0] GAIN_SEL_OPEN   = 4'hF;

  // Input source codes
  localparam logic [2:0] IN_SINGLE_ENDED = 3'h0;
  localparam logic [2:0] IN_AIN0         = 3'h1;
  localparam logic [2:0] IN_AIN3         = 3'h4;
  localparam logic [2:0] IN_ELECTRODE    = 3'h5;

  // Electrode load choices
  localparam logic [2:0] LOAD_0R    = 3'h0;
  localparam logic [2:0] LOAD_10R   = 3'h1;
  localparam logic [2:0] LOAD_30R   = 3'h2;
  localparam logic [2:0] LOAD_50R   = 3'h3;
  localparam logic [2:0] LOAD_100R  = 3'h4;
  localparam logic [2:0] LOAD_SHORT = 3'h6;
  localparam logic [2:0] LOAD_OPEN  = 3'h7;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== core/htc_electrode_decode.sv
/*
  Decoder for the dedicated electrode resistor configuration code.
  Purely combinational; the caller registers its outputs.
*/
module htc_electrode_decode
  import htc_pkg::*;
(
  input  wire logic [7:0] code,
  output logic      [2:0] load_sel,
  output logic      [3:0] gain_sel,
  output logic            short_both
);

  // Load resistor choice from the code
  always_comb
  begin
    unique case (code)
      8'h00, 8'h18, 8'h38, 8'h58, 8'h60, 8'h68, 8'h70, 8'h78, 8'h80, 8'h88: load_sel = LOAD_0R;
      8'h09, 8'h21, 8'h39, 8'h59, 8'h61, 8'h69, 8'h71, 8'h79, 8'h81, 8'h89: load_sel = LOAD_10R;
      8'h12, 8'h2A, 8'h4A, 8'h5A, 8'h62, 8'h6A, 8'h72, 8'h7A, 8'h82, 8'h8A: load_sel = LOAD_30R;
      8'h1B, 8'h33, 8'h4B, 8'h5B, 8'h63, 8'h6B, 8'h73, 8'h7B, 8'h83, 8'h8B: load_sel = LOAD_50R;
      8'h34, 8'h3C, 8'h54, 8'h5C, 8'h64, 8'h6C, 8'h74, 8'h7C, 8'h84, 8'h8C: load_sel = LOAD_100R;
      ELEC_SHORT_CODE: load_sel = LOAD_SHORT; // see [RQ12]
      default:         load_sel = LOAD_OPEN;  // see [RQ9]
    endcase
  end

  // Gain resistor step, 0 for the smallest up to 9 for the largest
  always_comb
  begin
    unique case (code)
      8'h00, 8'h09, 8'h12, 8'h1B, 8'h34: gain_sel = 4'h0; // see [RQ9]
      8'h18, 8'h21, 8'h2A, 8'h33, 8'h3C: gain_sel = 4'h1;
      8'h38, 8'h39, 8'h4A, 8'h4B, 8'h54: gain_sel = 4'h2;
      8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C: gain_sel = 4'h3;
      8'h60, 8'h61, 8'h62, 8'h63, 8'h64: gain_sel = 4'h4;
      8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C: gain_sel = 4'h5;
      8'h70, 8'h71, 8'h72, 8'h73, 8'h74: gain_sel = 4'h6;
      8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C: gain_sel = 4'h7;
      8'h80, 8'h81, 8'h82, 8'h83, 8'h84: gain_sel = 4'h8;
      8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C: gain_sel = 4'h9;
      default:                           gain_sel = GAIN_SEL_OPEN;
    endcase
  end

  // Both electrode resistors shorted
  assign short_both = (code == ELEC_SHORT_CODE); // see [RQ12]

endmodule // htc_electrode_decode

// ===== core/htc_config.sv
/*
  Register bank for the fast DAC offset correction and the fast TIA controls,
  reached over AXI4-Lite, driving registered analog control outputs.
  Assumes one clock, an asynchronous active-low reset and a bus master that
  keeps AXI4-Lite handshakes.
*/
// The AXI4-Lite interface to the registers was left to the implementer.
// Functional notes
// [RQ1] Offset correction is 12-bit two's complement in [11:0]; upper bits read zero.
// [RQ2] 0x7FF max positive, 0x800 max negative, 0x001/0xFFF half steps, 0x000 none.
// [RQ3] Offset applies only while the attenuator bit 12 of fast DAC control is clear.
// [RQ4] Offset register is write-protected by the calibration data lock.
// [RQ5] Writes to the offset while locked are ignored; stored value unchanged.
// [RQ6] TIA is off after reset; enabled only by front end control bit 11.
// [RQ7] TIA output is one selectable channel of the ADC input multiplexer.
// [RQ8] TIA input from single-ended pin, four analog pins or the electrode input.
// [RQ9] Electrode code decodes to load 0/10/30/50/100 ohm plus a gain choice.
// [RQ10] TIA common mode is the internal 1.11 V reference or zero-bias output.
// [RQ11] Software sets electrode code 0x97 and gain field 0xF for external gain.
// [RQ12] Electrode code 0x97 shorts both electrode resistors to the TIA output.
// [RQ13] Software routes the resistor pin to the TIA inverting input.
// [RQ14] Gain field codes 0-7 select resistors, 8-15 open; resets to 0xF.
module htc_config
  import htc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [11:0]      dac_offset_out,
  output logic             offset_active,
  output logic             tia_enable,
  output logic [2:0]       tia_input_sel,
  output logic             tia_cm_zero_bias,
  output logic             adc_tia_route,
  output logic [2:0]       electrode_load_sel,
  output logic [3:0]       electrode_gain_sel,
  output logic             electrode_short,
  output logic [2:0]       gain_res_sel,
  output logic             gain_res_open,
  output logic             ext_gain_mode
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic                    lock_q;
  logic [31:0]             front_end_q;
  logic [31:0]             fast_dac_q;
  logic [GAIN_RES_W-1:0]   gain_res_q;
  logic [ELEC_W-1:0]       elec_res_q;
  logic [TIA_CFG_W-1:0]    tia_cfg_q;
  logic [OFFSET_W-1:0]     offset_q;
  logic                    awready_q;
  logic                    wready_q;
  logic                    aw_got_q;
  logic                    w_got_q;
  logic [15:0]             waddr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    arready_q;
  logic                    rvalid_q;
  logic [31:0]             rdata_q;
  logic [1:0]              rresp_q;
  logic [11:0]             dac_offset_q;
  logic                    offset_active_q;
  logic                    tia_enable_q;
  logic [2:0]              tia_input_sel_q;
  logic                    tia_cm_q;
  logic                    adc_tia_route_q;
  logic [2:0]              elec_load_q;
  logic [3:0]              elec_gain_q;
  logic                    elec_short_q;
  logic [2:0]              gain_sel_q;
  logic                    gain_open_q;
  logic                    ext_gain_q;
  logic                    do_write;
  logic                    wr_offset;
  logic [2:0]              dec_load;
  logic [3:0]              dec_gain;
  logic                    dec_short;
  logic [31:0]             wr_word;

  // ***************************************************************
  // Helpers
  // ***************************************************************

  // Merge write data into an old word under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] mask;
    mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~mask) | (data & mask);
  endfunction

  // Address decode, used by both the read and the write path
  function automatic logic is_mapped(input logic [15:0] addr);
    return addr == OFS_CAL_LOCK || addr == OFS_FRONT_END || addr == OFS_FAST_DAC
        || addr == OFS_FAST_GAIN_RES || addr == OFS_ELECTRODE_RES || addr == OFS_TIA_CFG
        || addr == OFS_DAC_OFFSET_HS || addr == OFS_STATUS;
  endfunction

  // Present contents of a register as a bus word, for reads and strobed writes
  function automatic logic [31:0] reg_word(input logic [15:0] addr);
    logic [31:0] res;
    res = 32'h0000_0000;
    case (addr)
      OFS_CAL_LOCK:      res = {31'h0, lock_q};
      OFS_FRONT_END:     res = front_end_q;
      OFS_FAST_DAC:      res = fast_dac_q;
      OFS_FAST_GAIN_RES: res = {19'h0, gain_res_q};
      OFS_ELECTRODE_RES: res = {24'h0, elec_res_q};
      OFS_TIA_CFG:       res = {23'h0, tia_cfg_q};
      OFS_DAC_OFFSET_HS: res = {20'h0, offset_q}; // see [RQ1]
      OFS_STATUS:        res = {19'h0, gain_open_q, elec_gain_q, 1'b0, elec_load_q,
                                ext_gain_q, elec_short_q, tia_enable_q, offset_active_q};
      default:           res = 32'h0000_0000;
    endcase
    return res;
  endfunction

  // ***************************************************************
  // AXI4-Lite write channel
  // ***************************************************************

  // Write fires one cycle after both address and data are held
  assign do_write  = aw_got_q && w_got_q && !bvalid_q;
  assign wr_offset = do_write && (waddr_q == OFS_DAC_OFFSET_HS);

  // Addressed register merged with the held write data under its strobes
  always_comb
  begin
    wr_word = merge(reg_word(waddr_q), wdata_q, wstrb_q);
  end

  // Address and data capture, in either order
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      waddr_q   <= 16'h0000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        aw_got_q  <= 1'b1;
        awready_q <= 1'b0;
        waddr_q   <= {s_axi_awaddr[15:2], 2'b00};
      end
      if (s_axi_wvalid && wready_q)
      begin
        w_got_q  <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= (is_mapped(waddr_q) && waddr_q != OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // ***************************************************************
  // Register file
  // ***************************************************************

  // Control registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lock_q      <= 1'b0;
      front_end_q <= 32'h0000_0000;       // TIA off after reset, see [RQ6]
      fast_dac_q  <= 32'h0000_0000;
      gain_res_q  <= RST_FAST_GAIN_RES;   // see [RQ14]
      elec_res_q  <= RST_ELECTRODE_RES;
      tia_cfg_q   <= '0;
    end
    else if (do_write)
    begin
      unique case (waddr_q)
        OFS_CAL_LOCK:      lock_q      <= wr_word[LOCK_BIT];
        OFS_FRONT_END:     front_end_q <= wr_word;
        OFS_FAST_DAC:      fast_dac_q  <= wr_word;
        OFS_FAST_GAIN_RES: gain_res_q  <= wr_word[GAIN_RES_W-1:0];
        OFS_ELECTRODE_RES: elec_res_q  <= wr_word[ELEC_W-1:0];
        OFS_TIA_CFG:       tia_cfg_q   <= wr_word[TIA_CFG_W-1:0];
        default:           lock_q      <= lock_q;
      endcase
    end
  end

  // Offset correction, writable only while the lock is open
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      offset_q <= RST_DAC_OFFSET;
    end
    else if (wr_offset && !lock_q) // see [RQ4] [RQ5]
    begin
      offset_q <= wr_word[OFFSET_W-1:0]; // see [RQ1]
    end
  end

  // ***************************************************************
  // AXI4-Lite read channel
  // ***************************************************************

  // Read data is captured when the address is taken
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= is_mapped({s_axi_araddr[15:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      rdata_q   <= reg_word({s_axi_araddr[15:2], 2'b00}); // see [RQ1]
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ***************************************************************
  // Analog control outputs
  // ***************************************************************

  htc_electrode_decode u_elec_decode
  (
    .code       (elec_res_q),
    .load_sel   (dec_load),
    .gain_sel   (dec_gain),
    .short_both (dec_short)
  );

  // Offset passed to the DAC: raw two's complement when the attenuator is off
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dac_offset_q    <= 12'h000;
      offset_active_q <= 1'b0;
    end
    else
    begin
      offset_active_q <= !fast_dac_q[ATTEN_BIT];                          // see [RQ3]
      dac_offset_q    <= fast_dac_q[ATTEN_BIT] ? 12'h000 : offset_q;      // see [RQ2] [RQ3]
    end
  end

  // TIA enable, input, common mode and ADC routing
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tia_enable_q    <= 1'b0;
      tia_input_sel_q <= IN_SINGLE_ENDED;
      tia_cm_q        <= 1'b0;
      adc_tia_route_q <= 1'b0;
    end
    else
    begin
      tia_enable_q    <= front_end_q[TIA_EN_BIT];                                  // see [RQ6]
      tia_input_sel_q <= (tia_cfg_q[INSEL_LSB +: 3] > IN_ELECTRODE) ? IN_SINGLE_ENDED
                                                                    : tia_cfg_q[INSEL_LSB +: 3]; // see [RQ8]
      tia_cm_q        <= tia_cfg_q[CM_BIT];                                        // see [RQ10]
      adc_tia_route_q <= front_end_q[TIA_EN_BIT]
                         && tia_cfg_q[ADC_CH_LSB +: ADC_CH_W] == ADC_CH_TIA;       // see [RQ7]
    end
  end

  // Resistor selections
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      elec_load_q  <= LOAD_OPEN;
      elec_gain_q  <= GAIN_SEL_OPEN;
      elec_short_q <= 1'b0;
      gain_sel_q   <= 3'h0;
      gain_open_q  <= 1'b1;
      ext_gain_q   <= 1'b0;
    end
    else
    begin
      elec_load_q  <= dec_load;                                                  // see [RQ9]
      elec_gain_q  <= dec_gain;
      elec_short_q <= dec_short;                                                 // see [RQ12]
      gain_sel_q   <= gain_res_q[2:0];
      gain_open_q  <= gain_res_q[3];                                             // see [RQ14]
      ext_gain_q   <= dec_short && gain_res_q[GAIN_FIELD_W-1:0] == GAIN_EXT_CODE; // see [RQ11]
    end
  end

  // ***************************************************************
  // Port drive
  // ***************************************************************
  assign s_axi_awready      = awready_q;
  assign s_axi_wready       = wready_q;
  assign s_axi_bvalid       = bvalid_q;
  assign s_axi_bresp        = bresp_q;
  assign s_axi_arready      = arready_q;
  assign s_axi_rvalid       = rvalid_q;
  assign s_axi_rdata        = rdata_q;
  assign s_axi_rresp        = rresp_q;
  assign dac_offset_out     = dac_offset_q;
  assign offset_active      = offset_active_q;
  assign tia_enable         = tia_enable_q;
  assign tia_input_sel      = tia_input_sel_q;
  assign tia_cm_zero_bias   = tia_cm_q;
  assign adc_tia_route      = adc_tia_route_q;
  assign electrode_load_sel = elec_load_q;
  assign electrode_gain_sel = elec_gain_q;
  assign electrode_short    = elec_short_q;
  assign gain_res_sel       = gain_sel_q;
  assign gain_res_open      = gain_open_q;
  assign ext_gain_mode      = ext_gain_q;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  AST_OFFSET_GATED: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RQ3]
    fast_dac_q[ATTEN_BIT] |=> (dac_offset_q == 12'h000 && !offset_active_q))
    else $error("offset reached the DAC with the attenuator on");
  AST_OFFSET_PASS: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RQ2]
    !fast_dac_q[ATTEN_BIT] ##1 !fast_dac_q[ATTEN_BIT] |-> dac_offset_q == $past(offset_q))
    else $error("offset not passed unchanged with the attenuator off");
  AST_LOCK_HOLDS: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RQ5]
    (wr_offset && lock_q) |=> $stable(offset_q))
    else $error("locked offset register changed on a write");
  AST_OFFSET_CAUSE: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RQ4]
    !$stable(offset_q) |-> $past(wr_offset && !lock_q))
    else $error("offset changed without an unlocked write");
  AST_TIA_ENABLE: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RQ6]
    tia_enable_q |-> $past(front_end_q[TIA_EN_BIT]))
    else $error("TIA enabled without front end control bit 11");
  AST_SHORT_CODE: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RQ12]
    (elec_res_q == ELEC_SHORT_CODE) |=> (elec_short_q && elec_load_q == LOAD_SHORT))
    else $error("electrode code 0x97 did not short both resistors");
  AST_GAIN_OPEN: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RQ14]
    gain_res_q[3] |=> gain_open_q)
    else $error("gain field 8 to 15 not shown as open");
  AST_ADC_ROUTE: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RQ7]
    adc_tia_route_q |-> (tia_enable_q && $past(tia_cfg_q[ADC_CH_LSB +: ADC_CH_W]) == ADC_CH_TIA))
    else $error("TIA routed to the ADC while off or not selected");

endmodule // htc_config

// ===== dv/hs_tia_and_dac_offset_cfg_tb.sv
/*
  Self-checking bench for htc_config: AXI4-Lite register traffic and analog outputs.
  Assumes htc_pkg and the design files are compiled before this file.
*/
module hs_tia_and_dac_offset_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import htc_pkg::*;
  // ***************************************************************
  // Signals
  // ***************************************************************
  logic        ref_clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0]  wstrb = 4'hF, egain_o;
  logic [1:0]  bresp, rresp;
  logic [11:0] off_o;
  logic [2:0]  insel_o, load_o, gsel_o;
  logic        act_o, ten_o, cm_o, rte_o, sh_o, gop_o, ext_o;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [11:0] codes[5] = '{12'h7FF, 12'h800, 12'h001, 12'hFFF, 12'h000};
  // Electrode code, then the expected load choice and gain step
  logic [14:0] et[8] = '{15'h0000, 15'h0490, 15'h0920, 15'h0DB0, 15'h1A40, 15'h0C01,
                         15'h7FFF, 15'h4BEF};
  int          n_mismatch = 0, checks = 0, seed = 32'hadd1, i;

  // Clock of 4 ns period
  always #2 ref_clk = ~ref_clk;

  htc_config i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dac_offset_out(off_o), .offset_active(act_o), .tia_enable(ten_o),
    .tia_input_sel(insel_o), .tia_cm_zero_bias(cm_o), .adc_tia_route(rte_o),
    .electrode_load_sel(load_o), .electrode_gain_sel(egain_o), .electrode_short(sh_o),
    .gain_res_sel(gsel_o), .gain_res_open(gop_o), .ext_gain_mode(ext_o));

  // ***************************************************************
  // Tasks
  // ***************************************************************
  // Compares one result and counts it
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read response and data
  task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
    cmp(got, exp);
  endtask

  // Write response
  task automatic cmp_wr(input logic [33:0] got, input logic [33:0] exp);
    cmp(got, exp);
  endtask

  // Analog control outputs
  task automatic cmp_out(input logic [33:0] got, input logic [33:0] exp);
    cmp(got, exp);
  endtask

  // Prints the verdict and ends the run
  task automatic test_done;
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bus write; expected response noted for the monitor
  task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [1:0] r);
    bq.push_back(r);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Bus read; expected response and data noted for the monitor
  task automatic rd(input logic [15:0] a, input logic [1:0] r, input logic [31:0] v);
    rq.push_back({r, v});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Monitor takes the oldest note whenever a response appears
  always @(posedge ref_clk)
  begin
    if (rvalid && rready) cmp_rd({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) cmp_wr({32'h0, bresp}, {32'h0, bq.pop_front()});
  end

  // ***************************************************************
  // Main sequence and watchdog
  // ***************************************************************
  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    cmp_out(ten_o, 0);
    rd(OFS_DAC_OFFSET_HS, RESP_OKAY, 0);
    rd(OFS_FAST_GAIN_RES, RESP_OKAY, 32'hF);
    rd(OFS_FRONT_END, RESP_OKAY, 0);
    for (i = 0; i < 11; i++)
    begin
      d = (i < 5) ? {20'hFFFFF, codes[i]} : $random(seed);
      wr(OFS_DAC_OFFSET_HS, d, RESP_OKAY);
      rd(OFS_DAC_OFFSET_HS, RESP_OKAY, {20'h0, d[11:0]});
      cmp_out({off_o, act_o}, {d[11:0], 1'b1});
    end
    wr(OFS_FAST_DAC, 32'h1000, RESP_OKAY);
    cmp_out({off_o, act_o}, 0);
    wr(OFS_FAST_DAC, 0, RESP_OKAY);
    cmp_out({off_o, act_o}, {d[11:0], 1'b1});
    wr(OFS_CAL_LOCK, 1, RESP_OKAY);
    wr(OFS_DAC_OFFSET_HS, ~d, RESP_OKAY);
    rd(OFS_DAC_OFFSET_HS, RESP_OKAY, {20'h0, d[11:0]});
    cmp_out(off_o, d[11:0]);
    wr(OFS_CAL_LOCK, 0, RESP_OKAY);
    wr(OFS_DAC_OFFSET_HS, ~d, RESP_OKAY);
    cmp_out(off_o, 12'(~d[11:0]));
    wr(OFS_TIA_CFG, 32'h10, RESP_OKAY);
    cmp_out({ten_o, rte_o}, 0);
    wr(OFS_FRONT_END, 32'h800, RESP_OKAY);
    cmp_out({ten_o, rte_o}, 2'b11);
    for (i = 0; i < 8; i++)
    begin
      wr(OFS_TIA_CFG, {28'h1, i[0], i[2:0]}, RESP_OKAY);
      cmp_out({insel_o, cm_o, rte_o}, {(i > 5) ? 3'h0 : i[2:0], i[0], 1'b1});
    end
    foreach (et[i])
    begin
      wr(OFS_ELECTRODE_RES, {24'h0, et[i][14:7]}, RESP_OKAY);
      cmp_out({load_o, egain_o, sh_o}, {et[i][6:0], et[i][14:7] == 8'h97});
    end
    for (i = 0; i < 16; i++)
    begin
      wr(OFS_FAST_GAIN_RES, i, RESP_OKAY);
      cmp_out({gsel_o, gop_o, ext_o, sh_o}, {i[2:0], i[3], i == 15, 1'b1});
    end
    wr(OFS_TIA_CFG, 32'h11, RESP_OKAY);
    cmp_out({insel_o, ext_o}, {IN_AIN0, 1'b1});
    rd(OFS_STATUS, RESP_OKAY, 32'h1F6F);
    rd(16'h3000, RESP_SLVERR, 0);
    wr(OFS_STATUS, 32'hFFFF, RESP_SLVERR);
    test_done;
  end

  // Cuts a hang short
  initial
  begin
    #100000;
    n_mismatch++;
    test_done;
  end
endmodule // hs_tia_and_dac_offset_cfg_tb
